// ==== logic/wdt_sleep.sv ====
// watchdog, power-up timer, sleep and wake-up control
`timescale 1ns/1ps
`include "wdt_sleep_map.svh"
module wdt_sleep import wdt_sleep_pkg::*; #(
  parameter int WDT_BASE_TICKS = `WDT_PERIOD_MS * `WDT_RC_TICKS_PER_MS,
  parameter int TIMER_OVF_CYC = `TIMER_OVF_TOSC,
  parameter int PS_LOG2_SEL1 = 0,
  parameter int PS_LOG2_SEL2 = 4,
  parameter int PS_LOG2_SEL3 = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire reg_req_t req_i,
  output logic [7:0] rd_data_o,
  input wire options_t options_i,
  input wire logic wdt_rc_tick_i,
  input wire logic por_i,
  input wire logic master_clear_pin_n_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic sleep_instr_i,
  input wire logic stack_available_flag_i,
  input wire logic [`WAKE_SRCS-1:0] int_enable_i,
  input wire logic [`WAKE_SRCS-1:0] int_flag_i,
  output logic dev_reset_o,
  output logic core_hold_o,
  output logic wake_o,
  output logic vector_o,
  output logic osc_drv_en_o,
  output logic io_hold_o,
  output logic divided_clock_output_o,
  output logic master_clear_pin_oe_o
);

  pwr_state_t state;
  pwr_state_t next_state;
  options_t opts;
  logic [15:0] watchdog_counter;
  logic [7:0] postscale;
  logic [9:0] ost_cnt;
  logic [1:0] clk_div;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  logic global_int_disable;
  logic timer_mode;
  logic ost_rst;
  logic [`WAKE_SRCS-1:0] pend;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  function automatic logic is_crystal(input options_t o);
    return {o.osc_select_bit1, o.osc_select_bit0} == `OSC_LF ||
           {o.osc_select_bit1, o.osc_select_bit0} == `OSC_XT;
  endfunction

  // ratio per select is a parameter; 1:256 is the largest
  function automatic logic [7:0] ps_last(input logic [1:0] sel);
    int sh;
    case (sel)
      2'h2: sh = PS_LOG2_SEL2;
      2'h3: sh = PS_LOG2_SEL3;
      default: sh = PS_LOG2_SEL1;
    endcase
    return 8'((1 << sh) - 1); // RL23
  endfunction

  localparam logic [15:0] BASE_LAST = 16'(WDT_BASE_TICKS - 1);
  localparam logic [15:0] TIMER_LAST = 16'(TIMER_OVF_CYC - 1);
  localparam logic [9:0] OST_LAST = 10'(`OST_CYC - 1);

  // one enable-and-flag pair per wake-capable source
  genvar g;
  generate
    for (g = 0; g < `WAKE_SRCS; g++) begin : g_wake
      assign pend[g] = int_enable_i[g] & int_flag_i[g]; // RL18
    end
  endgenerate

  logic wd_on;
  logic base_hit;
  logic ps_hit;
  logic running;
  logic timeout;
  logic timer_ovf;
  logic power_up_timer_done;
  logic int_wake;
  logic reset_wake;
  logic master_clear_pin_low;
  logic sleep_go;
  logic clr_go;
  logic wdt_clr;
  logic ost_done;

  assign master_clear_pin_low = !master_clear_pin_n_i;
  assign running = state == ST_RUN;
  assign sleep_go = running && sleep_instr_i && !master_clear_pin_low;
  assign clr_go = running && clear_watchdog_instr_i && !sleep_instr_i;
  assign wd_on = opts.watchdog_period_select != 2'h0; // RL3
  assign base_hit = watchdog_counter == BASE_LAST;
  assign ps_hit = postscale == ps_last(opts.watchdog_period_select);
  assign timeout = !timer_mode && wd_on && wdt_rc_tick_i && base_hit && ps_hit &&
                   (running || state == ST_SLEEP); // RL1 RL2
  assign timer_ovf = timer_mode && wd_on && running && watchdog_counter == TIMER_LAST; // RL9
  assign power_up_timer_done = state == ST_POWER_UP_TIMER && wdt_rc_tick_i && base_hit && ps_hit; // RL8
  assign int_wake = state == ST_SLEEP && |pend; // RL15 RL20
  assign reset_wake = state == ST_SLEEP && (master_clear_pin_low || timeout); // RL15
  assign ost_done = ost_cnt == OST_LAST;
  assign wdt_clr = sleep_go || clr_go || int_wake || master_clear_pin_low || timeout ||
                   state == ST_OST; // RL5 RL12

  always_comb begin
    next_state = state;
    case (state)
      ST_POWER_UP_TIMER: if (power_up_timer_done) next_state = ST_RUN;
      ST_RUN: if (sleep_go) next_state = ST_SLEEP;
      ST_SLEEP: begin
        if (reset_wake || int_wake) begin
          next_state = is_crystal(opts) ? ST_OST : ST_RUN; // RL21
        end
      end
      ST_OST: if (ost_done) next_state = ST_RUN;
      default: next_state = ST_POWER_UP_TIMER;
    endcase
    if (por_i) next_state = ST_POWER_UP_TIMER;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) state <= ST_POWER_UP_TIMER;
    else state <= next_state;
  end

  // straps are taken while reset is held so they never change mid-run
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) opts <= options_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || por_i) ost_rst <= 1'b0;
    else if (state == ST_SLEEP) ost_rst <= reset_wake; // RL16
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state != ST_OST) ost_cnt <= 10'h000;
    else ost_cnt <= ost_cnt + 10'h001; // RL21
  end

  // counter and postscaler have no read or write path on the port
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || por_i || wdt_clr) begin // RL11
      watchdog_counter <= 16'h0000; // RL5
      postscale <= 8'h00;
    end else if (timer_mode && state != ST_POWER_UP_TIMER) begin
      if (wd_on && running) watchdog_counter <= timer_ovf ? 16'h0000 : watchdog_counter + 16'h0001; // RL10
    end else if (wdt_rc_tick_i && (wd_on || state == ST_POWER_UP_TIMER)) begin // RL6
      watchdog_counter <= base_hit ? 16'h0000 : watchdog_counter + 16'h0001; // RL4
      if (base_hit) postscale <= ps_hit ? 8'h00 : postscale + 8'h01; // RL4
    end
  end

  // a hardware event overrides a same-cycle instruction write to the flags
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || por_i) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1; // RL17
    end else begin
      if (sleep_go) begin
        timeout_flag_n <= 1'b1; // RL12
        powerdown_flag_n <= 1'b0; // RL12
      end
      if (clr_go) begin
        timeout_flag_n <= 1'b1; // RL10
        powerdown_flag_n <= 1'b1;
      end
      if (timeout || timer_ovf) timeout_flag_n <= 1'b0; // RL7 RL9
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      global_int_disable <= 1'b1;
      timer_mode <= 1'b0;
    end else if (req_i.we) begin
      if (hit(req_i.addr, `STATUS_ADDR)) global_int_disable <= req_i.wdata[`STAT_GLOBAL_INT_DISABLE_BIT];
      if (hit(req_i.addr, `CTRL_ADDR)) timer_mode <= req_i.wdata[`CTRL_TIMER_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) rd_data_o <= 8'h00;
    else if (req_i.re && hit(req_i.addr, `STATUS_ADDR)) begin
      rd_data_o <= 8'h00;
      rd_data_o[`STAT_STACK_BIT] <= stack_available_flag_i;
      rd_data_o[`STAT_GLOBAL_INT_DISABLE_BIT] <= global_int_disable;
      rd_data_o[`STAT_TO_BIT] <= timeout_flag_n;
      rd_data_o[`STAT_PD_BIT] <= powerdown_flag_n;
    end else if (req_i.re && hit(req_i.addr, `OPTIONS_ADDR)) begin
      rd_data_o <= {1'b0, opts.processor_mode_bit1, 1'b0, opts.processor_mode_bit0,
                    opts.watchdog_period_select, opts.osc_select_bit1, opts.osc_select_bit0};
    end else if (req_i.re && hit(req_i.addr, `CTRL_ADDR)) begin
      rd_data_o <= {7'h00, timer_mode};
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  logic int_resume;
  assign int_resume = (state == ST_SLEEP && int_wake && !reset_wake && !is_crystal(opts)) ||
                      (state == ST_OST && ost_done && !ost_rst);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      dev_reset_o <= 1'b1;
      core_hold_o <= 1'b0;
      wake_o <= 1'b0;
      vector_o <= 1'b0;
      osc_drv_en_o <= 1'b1;
      io_hold_o <= 1'b0;
      master_clear_pin_oe_o <= 1'b0;
    end else begin
      dev_reset_o <= next_state == ST_POWER_UP_TIMER || master_clear_pin_low || timeout ||
                     (next_state == ST_OST && (ost_rst || reset_wake)); // RL2 RL16
      core_hold_o <= next_state == ST_OST; // RL21
      wake_o <= int_resume; // RL16 RL19
      vector_o <= int_resume && !global_int_disable; // RL19
      osc_drv_en_o <= next_state != ST_SLEEP; // RL12
      io_hold_o <= next_state == ST_SLEEP; // RL13
      master_clear_pin_oe_o <= 1'b0; // RL14
    end
  end

  // clock output only exists in rc mode and stops with the oscillator
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      clk_div <= 2'h0;
      divided_clock_output_o <= 1'b0;
    end else if ({opts.osc_select_bit1, opts.osc_select_bit0} == `OSC_RC && state != ST_SLEEP) begin
      clk_div <= clk_div + 2'h1;
      divided_clock_output_o <= clk_div[1]; // RL22
    end else begin
      clk_div <= 2'h0;
      divided_clock_output_o <= 1'b0;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_sleep_entered;
    sleep_go && !por_i;
  endsequence
  sequence s_asleep;
    !osc_drv_en_o && io_hold_o;
  endsequence

  property p_sleep_entry;
    s_sleep_entered |=> !powerdown_flag_n && timeout_flag_n ##0 s_asleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry flags wrong"); // RL12

  property p_disabled;
    !wd_on && !por_i && state != ST_POWER_UP_TIMER |=> $stable(timeout_flag_n) || $past(clr_go) || $past(sleep_go);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled watchdog changed flag"); // RL3

  property p_clear;
    clr_go && !por_i && !timeout && !timer_ovf |=> watchdog_counter == 16'h0000 && postscale == 8'h00 && timeout_flag_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear counter"); // RL5

  property p_timeout;
    timeout && !por_i |=> dev_reset_o && !timeout_flag_n && !master_clear_pin_oe_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out without reset"); // RL2

  property p_timer_ovf;
    timer_ovf && !por_i |=> !timeout_flag_n && watchdog_counter == 16'h0000;
  endproperty
  a_timer_ovf: assert property (p_timer_ovf) else $error("timer overflow missed"); // RL9

  property p_timer_sleep;
    timer_mode && state == ST_SLEEP && !por_i && !int_wake && !reset_wake |=> $stable(watchdog_counter);
  endproperty
  a_timer_sleep: assert property (p_timer_sleep) else $error("timer ran in sleep"); // RL10

  sequence s_rc_int_wake;
    state == ST_SLEEP && int_wake && !reset_wake && !is_crystal(opts) && !por_i;
  endsequence

  property p_wake_vector;
    s_rc_int_wake |=> wake_o && vector_o == !global_int_disable && !dev_reset_o;
  endproperty
  a_wake_vector: assert property (p_wake_vector) else $error("interrupt wake wrong"); // RL19

  property p_ost_hold;
    $rose(core_hold_o) |-> core_hold_o [*8];
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("start-up hold too short"); // RL21

  property p_divided_clock_output;
    !$stable(divided_clock_output_o) && osc_drv_en_o && $past(osc_drv_en_o) |=> $stable(divided_clock_output_o);
  endproperty
  a_divided_clock_output: assert property (p_divided_clock_output) else $error("clock output not divided by four"); // RL22

  property p_master_clear_pin_oe;
    1'b1 |-> !master_clear_pin_oe_o;
  endproperty
  a_master_clear_pin_oe: assert property (p_master_clear_pin_oe) else $error("master clear driven"); // RL14

  // power-up timer, counting, wake and flag checks
  property p_power_up_timer_hold;
    state == ST_POWER_UP_TIMER && !power_up_timer_done |=> dev_reset_o;
  endproperty
  a_power_up_timer_hold: assert property (p_power_up_timer_hold) else $error("power-up timer released early"); // RL8

  property p_power_up_timer_done;
    power_up_timer_done && !por_i && !master_clear_pin_low |=> !dev_reset_o && running;
  endproperty
  a_power_up_timer_done: assert property (p_power_up_timer_done) else $error("power-up timer did not release"); // RL8

  property p_wdt_count;
    running && !timer_mode && wd_on && wdt_rc_tick_i && !wdt_clr && !base_hit && !por_i |=>
      watchdog_counter == $past(watchdog_counter) + 16'h0001;
  endproperty
  a_wdt_count: assert property (p_wdt_count) else $error("watchdog did not count a tick"); // RL6

  property p_timer_count;
    timer_mode && running && wd_on && !wdt_clr && !timer_ovf && !por_i |=>
      watchdog_counter == $past(watchdog_counter) + 16'h0001;
  endproperty
  a_timer_count: assert property (p_timer_count) else $error("plain timer did not count a clock"); // RL9

  property p_ovf_no_reset;
    timer_ovf && !por_i && !master_clear_pin_low |=> !dev_reset_o;
  endproperty
  a_ovf_no_reset: assert property (p_ovf_no_reset) else $error("plain timer overflow reset the device"); // RL9

  property p_int_clear;
    int_wake && !por_i |=> watchdog_counter == 16'h0000 && postscale == 8'h00;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt wake left watchdog running"); // RL5

  property p_sleep_hold;
    state == ST_SLEEP && next_state == ST_SLEEP |=> io_hold_o && !osc_drv_en_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("pins or oscillator not held in sleep"); // RL13

  property p_pending_wake;
    state == ST_SLEEP && |pend && !por_i |=> state != ST_SLEEP && !powerdown_flag_n;
  endproperty
  a_pending_wake: assert property (p_pending_wake) else $error("pending interrupt did not end sleep"); // RL20

  property p_master_clear_pin_wake;
    state == ST_SLEEP && master_clear_pin_low && !por_i |=> dev_reset_o && !io_hold_o;
  endproperty
  a_master_clear_pin_wake: assert property (p_master_clear_pin_wake) else $error("master clear did not wake with reset"); // RL15

  property p_ost_busy;
    state == ST_OST && !ost_done && !por_i |=> core_hold_o;
  endproperty
  a_ost_busy: assert property (p_ost_busy) else $error("start-up wait released early"); // RL21

  property p_wake_pulse;
    wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("interrupt wake pulse too long"); // RL16

  // both flags must read as set on the first cycle out of reset
  property p_powerup_flags;
    $rose(rstn_i) |-> powerdown_flag_n && timeout_flag_n;
  endproperty
  a_powerup_flags: assert property (p_powerup_flags) else $error("flags not set after power-up"); // RL17

endmodule // wdt_sleep

// ==== pkg/wdt_sleep_map.svh ====
// register offsets, field positions and timing counts of the watchdog and sleep block
// Function
// [RL1] watchdog counts on its own rc clock
// [RL2] watchdog time-out resets device, even sleeping
// [RL3] period select zero disables watchdog permanently
// [RL4] 12 ms base period, postscaler up to 1:256
// [RL5] clear on reset, sleep, clear, interrupt wake
// [RL6] counting starts first edge after reset
// [RL7] time-out clears the time-out flag
// [RL8] watchdog acts as power-up timer
// [RL9] plain timer overflows after 65536 clocks
// [RL10] clear sets flag; timer frozen in sleep
// [RL11] counter and postscaler not software visible
// [RL12] sleep clears counter, flags, stops oscillator; code sets time-out flag, clears power-down flag
// [RL13] port pins hold their state in sleep
// [RL14] watchdog reset never drives master clear
// [RL15] listed resets and interrupts wake from sleep
// [RL16] reset wake resets; interrupt wake continues
// [RL17] power-down flag set on power-up
// [RL18] enabled source wakes regardless of global disable
// [RL19] prefetched instruction runs, then vector if enabled
// [RL20] pending enabled interrupt ends sleep at once
// [RL21] crystal modes wait 1024 oscillator periods
// [RL22] rc mode drives clock divided by four
// [RL23] postscaler ratio per select is parameter
`ifndef WDT_SLEEP_MAP_SVH
`define WDT_SLEEP_MAP_SVH
`define STATUS_ADDR 8'h06
`define OPTIONS_ADDR 8'h07
`define CTRL_ADDR 8'h08
`define STAT_STACK_BIT 5
`define STAT_GLOBAL_INT_DISABLE_BIT 4
`define STAT_TO_BIT 3
`define STAT_PD_BIT 2
`define CTRL_TIMER_BIT 0
`define OSC_LF 2'h0
`define OSC_RC 2'h1
`define OSC_XT 2'h2
`define WDT_PERIOD_MS 12
`define WDT_RC_TICKS_PER_MS 1000
`define OST_TOSC 1024
`define OST_CYC (`OST_TOSC)
`define TIMER_OVF_TOSC 65536
`define WAKE_SRCS 7
`endif

// ==== pkg/wdt_sleep_pkg.sv ====
// types shared by the watchdog and sleep block
package wdt_sleep_pkg;
  typedef enum {ST_POWER_UP_TIMER, ST_RUN, ST_SLEEP, ST_OST} pwr_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } reg_req_t;
  typedef struct packed {
    logic processor_mode_bit1;
    logic processor_mode_bit0;
    logic [1:0] watchdog_period_select;
    logic osc_select_bit1;
    logic osc_select_bit0;
  } options_t;
endpackage

// ==== tb/core_model.sv ====
// processor core model that issues sleep and clear-watchdog instructions
`timescale 1ns/1ps
module core_model (
  input wire logic mclk_i,
  input wire logic hold_i,
  input wire logic go_sleep_i,
  input wire logic go_clear_i,
  output logic sleep_instr_o,
  output logic clear_watchdog_instr_o
);
  initial sleep_instr_o = 1'b0;
  initial clear_watchdog_instr_o = 1'b0;
  // a core held in reset or start-up executes nothing, so no pulse leaks out then
  always @(posedge mclk_i) begin
    sleep_instr_o <= go_sleep_i & ~hold_i;
    clear_watchdog_instr_o <= go_clear_i & ~hold_i;
  end
endmodule // core_model

// ==== tb/watchdog_and_sleep_control_tb_top.sv ====
// self-checking bench for the watchdog and sleep block
`timescale 1ns/1ps
`include "wdt_sleep_map.svh"
module watchdog_and_sleep_control_tb_top import wdt_sleep_pkg::*;;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  reg_req_t req = '0;
  options_t opts = '0;
  logic rc_tick = 1'b0;
  logic master_clear_pin_n = 1'b1;
  logic go_sleep = 1'b0;
  logic go_clear = 1'b0;
  logic [`WAKE_SRCS-1:0] ien = '0;
  logic [`WAKE_SRCS-1:0] ifl = '0;
  logic [7:0] rd_data_o;
  logic sleep_instr, clear_instr, dev_reset_o, core_hold_o, wake_o, vector_o;
  logic osc_drv_en_o, io_hold_o, div_clk, master_clear_pin_oe;
  logic [1:0] tcnt = 2'h0;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  always #25 mclk_i = ~mclk_i;
  // watchdog rc tick every fourth main clock
  always @(posedge mclk_i) begin
    tcnt <= tcnt + 2'h1;
    rc_tick <= (tcnt == 2'h3);
  end
  wdt_sleep #(.WDT_BASE_TICKS(8), .TIMER_OVF_CYC(16)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_i(req),
    .rd_data_o(rd_data_o), .options_i(opts), .wdt_rc_tick_i(rc_tick), .por_i(1'b0),
    .master_clear_pin_n_i(master_clear_pin_n), .clear_watchdog_instr_i(clear_instr), .sleep_instr_i(sleep_instr),
    .stack_available_flag_i(1'b1), .int_enable_i(ien), .int_flag_i(ifl), .dev_reset_o(dev_reset_o),
    .core_hold_o(core_hold_o), .wake_o(wake_o), .vector_o(vector_o), .osc_drv_en_o(osc_drv_en_o),
    .io_hold_o(io_hold_o), .divided_clock_output_o(div_clk), .master_clear_pin_oe_o(master_clear_pin_oe));
  core_model core (.mclk_i(mclk_i), .hold_i(dev_reset_o | core_hold_o), .go_sleep_i(go_sleep),
    .go_clear_i(go_clear), .sleep_instr_o(sleep_instr), .clear_watchdog_instr_o(clear_instr));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge mclk_i);
    req <= '0;
    #1;
    cmp(rd_data_o & m, exp);
  endtask
  task automatic instr(input logic s);
    if (s) go_sleep <= 1'b1;
    else go_clear <= 1'b1;
    @(posedge mclk_i);
    go_sleep <= 1'b0;
    go_clear <= 1'b0;
    // one edge through the core model, one for the block to act on it
    @(posedge mclk_i);
  endtask
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim) begin
      @(posedge mclk_i);
      #1;
      cnt++;
      case (sel)
        0: hit = (dev_reset_o === 1'b1);
        1: hit = (dev_reset_o === 1'b0);
        2: hit = (wake_o === 1'b1);
        default: hit = (core_hold_o === 1'b1);
      endcase
    end
    if (!hit) begin
      n_mismatch++;
      $display("BAD t=%0t wait=%h got=%h exp=%h", $time, sel, 1'b0, 1'b1);
    end
  endtask
  task automatic count_div(output int rises);
    logic last;
    rises = 0;
    last = div_clk;
    repeat (16) begin
      @(posedge mclk_i);
      #1;
      if (div_clk === 1'b1 && last === 1'b0) rises++;
      last = div_clk;
    end
  endtask
  task automatic do_reset(input options_t o);
    opts <= o;
    rstn_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    wait_for(1, 400, n);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    finish_test();
  end
  initial begin
    do_reset('{processor_mode_bit1: 1'b1, processor_mode_bit0: 1'b0, watchdog_period_select: 2'h1,
      osc_select_bit1: 1'b0, osc_select_bit0: 1'b1});
    rd(`STATUS_ADDR, 8'hff, 8'h3c);
    rd(`OPTIONS_ADDR, 8'hff, 8'h45);
    rd(8'h20, 8'hff, 8'h00);
    wr(`STATUS_ADDR, 8'h00);
    rd(`STATUS_ADDR, 8'hff, 8'h2c);
    wr(`STATUS_ADDR, 8'hff);
    rd(`STATUS_ADDR, 8'hff, 8'h3c);
    instr(1'b0);
    count_div(n);
    cmp(8'(n), 8'h04);
    $display("test registers done");
    instr(1'b0);
    wait_for(0, 100, n);
    cmp({7'h0, n inside {[28:40]}}, 8'h01);
    cmp({7'h0, master_clear_pin_oe}, 8'h00);
    @(posedge mclk_i);
    #1;
    cmp({7'h0, dev_reset_o}, 8'h00);
    rd(`STATUS_ADDR, 8'h0c, 8'h04);
    instr(1'b0);
    rd(`STATUS_ADDR, 8'h0c, 8'h0c);
    $display("test watchdog time-out done");
    for (int i = 0; i < `WAKE_SRCS; i++) begin
      wr(`STATUS_ADDR, {3'h0, i[0], 4'h0});
      ien <= 7'(1 << i);
      ifl <= 7'(1 << i);
      instr(1'b1);
      wait_for(2, 20, n);
      cmp({7'h0, vector_o}, {7'h0, ~i[0]});
      ien <= '0;
      ifl <= '0;
      @(posedge mclk_i);
      #1;
      cmp({6'h0, io_hold_o, osc_drv_en_o}, 8'h01);
      rd(`STATUS_ADDR, 8'h0c, 8'h08);
    end
    $display("test pending wake sources done");
    wr(`STATUS_ADDR, 8'h00);
    ien <= 7'h01;
    ifl <= 7'h7e;
    instr(1'b1);
    repeat (6) @(posedge mclk_i);
    #1;
    cmp({6'h0, io_hold_o, osc_drv_en_o}, 8'h02);
    ifl <= 7'h7f;
    wait_for(2, 10, n);
    cmp({7'h0, vector_o}, 8'h01);
    ien <= '0;
    ifl <= '0;
    instr(1'b1);
    repeat (3) @(posedge mclk_i);
    master_clear_pin_n <= 1'b0;
    wait_for(0, 5, n);
    master_clear_pin_n <= 1'b1;
    wait_for(1, 400, n);
    rd(`STATUS_ADDR, 8'h0c, 8'h08);
    instr(1'b1);
    wait_for(0, 100, n);
    rd(`STATUS_ADDR, 8'h0c, 8'h00);
    $display("test sleep and wake done");
    wr(`CTRL_ADDR, 8'h01);
    instr(1'b0);
    repeat (22) @(posedge mclk_i);
    #1;
    cmp({7'h0, dev_reset_o}, 8'h00);
    rd(`STATUS_ADDR, 8'h0c, 8'h04);
    instr(1'b0);
    rd(`STATUS_ADDR, 8'h0c, 8'h0c);
    instr(1'b1);
    repeat (20) @(posedge mclk_i);
    ien <= 7'h01;
    ifl <= 7'h01;
    wait_for(2, 10, n);
    ien <= '0;
    ifl <= '0;
    rd(`STATUS_ADDR, 8'h0c, 8'h08);
    $display("test plain timer done");
    do_reset('{processor_mode_bit1: 1'b0, processor_mode_bit0: 1'b0, watchdog_period_select: 2'h0,
      osc_select_bit1: 1'b1, osc_select_bit0: 1'b0});
    count_div(n);
    cmp(8'(n), 8'h00);
    ien <= 7'h08;
    ifl <= 7'h08;
    instr(1'b1);
    wait_for(3, 10, n);
    wait_for(2, 1100, n);
    cmp({7'h0, n inside {[1020:1030]}}, 8'h01);
    cmp({7'h0, dev_reset_o}, 8'h00);
    $display("test crystal start-up done");
    finish_test();
  end
endmodule // watchdog_and_sleep_control_tb_top
